// File: rtl/flrc_pkg.sv
/*
 Constants, opcodes and lookup functions for the flash lock and reset command block.
 Assumes a 256 Mbit array of 64 KB blocks whose lowest and highest blocks are split into 4 KB sectors.
*/
package flrc_pkg;

	// Instruction codes handled here
	localparam logic [7:0] OP_EXIT_QPI = 8'hFF;
	localparam logic [7:0] OP_ENTER_QPI = 8'h38;
	localparam logic [7:0] OP_LOCK = 8'h36;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam logic [7:0] OP_READ_LOCK = 8'h3D;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;

	// Frame layout in link clocks
	localparam logic [5:0] OP_CLOCKS_SPI = 6'h08;
	localparam logic [5:0] OP_CLOCKS_QPI = 6'h02;
	localparam logic [5:0] ADDR3_CLOCKS_SPI = 6'h18;
	localparam logic [5:0] ADDR4_CLOCKS_SPI = 6'h20;
	localparam logic [5:0] ADDR3_CLOCKS_QPI = 6'h06;
	localparam logic [5:0] ADDR4_CLOCKS_QPI = 6'h08;

	// Lock bit partition: 16 low sectors, 510 middle blocks, 16 high sectors
	localparam int LOCK_COUNT = 542;
	localparam logic [8:0] LAST_BLOCK = 9'h1FF;
	localparam logic [9:0] LOCK_MID_OFFSET = 10'h00F;
	localparam logic [9:0] LOCK_TOP_BASE = 10'h20E;
	localparam logic [15:0] BLOCK_TOTAL = 16'h0200;
	localparam logic LOCK_RESET_VALUE = 1'b1;

	// Reset recovery interval, rounded up to whole reference clocks
	localparam int REF_CLK_PERIOD_NS = 25;
	localparam int RESET_RECOVERY_NS = 30000;
	localparam int RESET_RECOVERY_CYCLES = (RESET_RECOVERY_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam logic [10:0] RECOVERY_LAST = 11'(RESET_RECOVERY_CYCLES - 1);

	// Software reset sequence, Gray coded from idle through recover; the return from recover to idle flips both bits
	typedef enum logic [1:0] {
		RST_IDLE = 2'h0,
		RST_ARMED = 2'h1,
		RST_RECOVER = 2'h3
	} flrc_rst_e;

	// Map an address to the one lock bit that covers it
	function automatic logic [9:0] lock_index(input logic [31:0] addr);
		logic [8:0] blk;
		blk = addr[24:16];
		if (blk == 9'h000) begin
			lock_index = {6'h00, addr[15:12]};
		end else if (blk == LAST_BLOCK) begin
			lock_index = LOCK_TOP_BASE + {6'h00, addr[15:12]};
		end else begin
			lock_index = {1'b0, blk} + LOCK_MID_OFFSET;
		end
	endfunction

	// Legacy protection: 2^(field-1) blocks from top or bottom, optionally complemented
	function automatic logic field_protected(input logic [31:0] addr, input logic [3:0] prot_field,
			input logic from_bottom, input logic invert);
		logic [15:0] n;
		logic [15:0] blk;
		logic hit;
		n = (prot_field == 4'h0) ? 16'h0000 : (16'h0001 << (prot_field - 4'h1));
		blk = {7'h00, addr[24:16]};
		if (n >= BLOCK_TOTAL) begin
			hit = 1'b1;
		end else if (from_bottom) begin
			hit = blk < n;
		end else begin
			hit = blk >= (BLOCK_TOTAL - n);
		end
		field_protected = hit ^ invert;
	endfunction

endpackage

// File: rtl/flrc_sync.sv
/*
 Two flip-flop level synchroniser.
 Assumes the input is a level that stays put for several destination clocks.
*/
module flrc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Destination clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_q <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule

// File: rtl/flrc_top.sv
/*
 Command interpreter for four-wire mode exit/entry, volatile block and sector locks, and software reset.
 Assumes the host frames every instruction with chip select, keeps chip select high for at least four
 reference clocks between frames, and that the array engines honour o_soft_reset and o_check_protected.
*/
// Behaviour
// - opcode FFh in four-wire mode leaves it
// - leaving four-wire mode keeps latch, suspend, wrap
// - lock bits protect only when scheme bit set
// - scheme bit clear uses complement, top/bottom, field
// - lock bits volatile, all set after reset
// - opcode 36h plus address sets lock bit
// - opcode 39h plus address clears lock bit
// - opcode 3Dh shifts lock byte out, MSB first
// - returned byte LSB one means locked
// - address is 32 bits in four-byte mode
// - opcode 7Eh sets every lock bit
// - opcode 98h clears every lock bit
// - global opcodes sampled rising, completed by select
// - 66h then 99h resets in either mode
// - anything but 99h or 66h after 66h disarms reset
// - accepted reset restores power-on defaults
// - instructions ignored for 30us after reset
// - entering four-wire mode needs quad enable set
module flrc_top (
	// Reference clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// Serial link from the host
	input wire logic i_spi_clk,
	input wire logic i_spi_cs_n,
	input wire logic [3:0] i_io_in,
	output logic [3:0] o_io_out,
	output logic [3:0] o_io_oe,
	// Configuration from the status logic
	input wire logic i_quad_enable_bit,
	input wire logic i_four_byte_mode,
	input wire logic i_protect_scheme_select,
	input wire logic i_protect_complement,
	input wire logic i_top_bottom_select,
	input wire logic [3:0] i_block_protect_field,
	// Protection query from the array engines
	input wire logic [31:0] i_check_addr,
	output logic o_check_protected,
	// Mode and reset status
	output logic o_four_wire_command_mode,
	output logic o_soft_reset,
	output logic o_reset_busy
);
	import flrc_pkg::*;

	// Link domain state
	logic lk_in_frame_q;
	logic lk_qpi_q;
	logic lk_four_q;
	logic lk_ignore_q;
	logic [5:0] lk_cnt_q;
	logic [7:0] lk_op_q;
	logic [31:0] lk_addr_q;
	logic lk_op_done_q;
	logic lk_addr_done_q;
	logic [2:0] lk_out_cnt_q;
	logic lk_start;
	logic lk_qpi_now;
	logic lk_four_now;
	logic [5:0] lk_cnt_now;
	logic [5:0] lk_op_clks;
	logic [5:0] lk_addr_clks;
	logic lk_frame_clr;
	logic lk_read_go;
	logic [7:0] lk_lock_byte;

	// Reference domain state
	logic cs_sync;
	logic cs_prev_q;
	logic frame_end;
	logic commit;
	logic accept_reset;
	logic busy_q;
	logic qpi_q;
	logic [LOCK_COUNT-1:0] lock_q;
	logic [10:0] rcv_cnt_q;
	flrc_rst_e rst_state_q;
	flrc_rst_e rst_state_d;

	// Chip select, raised asynchronously, clears the frame flag and releases the data pins
	assign lk_frame_clr = ~i_rstn | i_spi_cs_n;

	// Mode values are taken from the reference side only at the first edge of a frame;
	// the reference side changes them only after it has seen chip select high, so they are still.
	always_comb begin
		lk_start = ~lk_in_frame_q;
		lk_qpi_now = lk_start ? qpi_q : lk_qpi_q;
		lk_four_now = lk_start ? i_four_byte_mode : lk_four_q;
		lk_cnt_now = lk_start ? 6'h00 : lk_cnt_q;
		lk_op_clks = lk_qpi_now ? OP_CLOCKS_QPI : OP_CLOCKS_SPI;
		if (lk_qpi_now) begin
			lk_addr_clks = lk_four_now ? ADDR4_CLOCKS_QPI : ADDR3_CLOCKS_QPI;
		end else begin
			lk_addr_clks = lk_four_now ? ADDR4_CLOCKS_SPI : ADDR3_CLOCKS_SPI;
		end
	end

	// Frame flag, cleared by chip select while the link clock may stand still
	always_ff @(posedge i_spi_clk or posedge lk_frame_clr) begin
		if (lk_frame_clr) begin
			lk_in_frame_q <= 1'b0;
		end else begin
			lk_in_frame_q <= 1'b1;
		end
	end

	// Frame mode snapshot
	always_ff @(posedge i_spi_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lk_qpi_q <= 1'b0;
			lk_four_q <= 1'b0;
			lk_ignore_q <= 1'b0;
		end else if (lk_start) begin
			lk_qpi_q <= qpi_q;
			lk_four_q <= i_four_byte_mode;
			// frames begun in recovery are dropped
			lk_ignore_q <= busy_q;
		end
	end

	// Clock counter, saturating so long frames cannot wrap into the opcode slot
	always_ff @(posedge i_spi_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lk_cnt_q <= 6'h00;
		end else if (lk_cnt_now != 6'h3F) begin
			lk_cnt_q <= lk_cnt_now + 6'h01;
		end else begin
			lk_cnt_q <= lk_cnt_now;
		end
	end

	// Opcode and address shifters; held after the frame so the reference side can read them
	always_ff @(posedge i_spi_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lk_op_q <= 8'h00;
			lk_addr_q <= 32'h0000_0000;
			lk_op_done_q <= 1'b0;
			lk_addr_done_q <= 1'b0;
		end else begin
			if (lk_start) begin
				lk_addr_q <= 32'h0000_0000;
				lk_op_done_q <= 1'b0;
				lk_addr_done_q <= 1'b0;
			end
			// instruction bits taken on rising edges
			if (lk_cnt_now < lk_op_clks) begin
				lk_op_q <= lk_qpi_now ? {lk_op_q[3:0], i_io_in} : {lk_op_q[6:0], i_io_in[0]};
				if (lk_cnt_now == lk_op_clks - 6'h01) begin
					lk_op_done_q <= 1'b1;
				end
			end else if (lk_cnt_now < lk_op_clks + lk_addr_clks) begin
				lk_addr_q <= lk_qpi_now ? {lk_addr_q[27:0], i_io_in} : {lk_addr_q[30:0], i_io_in[0]};
				if (lk_cnt_now == lk_op_clks + lk_addr_clks - 6'h01) begin
					lk_addr_done_q <= 1'b1;
				end
			end
		end
	end

	// Lock bits do not change while a frame is open, so the lookup is stable here
	// locked shows as a one in the least significant bit
	assign lk_lock_byte = {7'h00, lock_q[lock_index(lk_addr_q)]};
	assign lk_read_go = lk_in_frame_q & lk_op_done_q & lk_addr_done_q & ~lk_ignore_q & (lk_op_q == OP_READ_LOCK);

	// lock byte driven on falling edges, most significant first, repeated while clocked
	always_ff @(negedge i_spi_clk or posedge lk_frame_clr) begin
		if (lk_frame_clr) begin
			lk_out_cnt_q <= 3'h0;
			o_io_out <= 4'h0;
			o_io_oe <= 4'h0;
		end else if (lk_read_go) begin
			lk_out_cnt_q <= lk_out_cnt_q + 3'h1;
			if (lk_qpi_q) begin
				o_io_oe <= 4'hF;
				o_io_out <= lk_out_cnt_q[0] ? lk_lock_byte[3:0] : lk_lock_byte[7:4];
			end else begin
				o_io_oe <= 4'h2;
				o_io_out <= {2'h0, lk_lock_byte[3'h7 - lk_out_cnt_q], 1'b0};
			end
		end else begin
			o_io_oe <= 4'h0;
			o_io_out <= 4'h0;
		end
	end

	// Chip select level into the reference domain
	flrc_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) u_cs_sync (
		.i_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async(i_spi_cs_n),
		.o_sync(cs_sync)
	);

	// Frame end edge; link registers are still from here on until the next frame starts
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cs_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= cs_sync;
		end
	end

	// an instruction takes effect only once chip select has gone high
	assign frame_end = cs_sync & ~cs_prev_q;
	assign commit = frame_end & ~busy_q & ~lk_ignore_q & lk_op_done_q;
	assign accept_reset = commit & (lk_op_q == OP_RESET) & (rst_state_q == RST_ARMED);

	// Software reset sequence
	always_comb begin
		rst_state_d = rst_state_q;
		case (rst_state_q)
			RST_IDLE: begin
				if (commit && lk_op_q == OP_RESET_ENABLE) begin
					rst_state_d = RST_ARMED;
				end
			end
			RST_ARMED: begin
				if (accept_reset) begin
					rst_state_d = RST_RECOVER;
				end else if (commit && lk_op_q != OP_RESET_ENABLE) begin
					rst_state_d = RST_IDLE;
				end
			end
			RST_RECOVER: begin
				// stay deaf for the recovery interval
				if (rcv_cnt_q == RECOVERY_LAST) begin
					rst_state_d = RST_IDLE;
				end
			end
			default: begin
				rst_state_d = RST_IDLE;
			end
		endcase
	end

	// Reset state, busy flag and reset pulse
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_state_q <= RST_IDLE;
			busy_q <= 1'b0;
			o_soft_reset <= 1'b0;
		end else begin
			rst_state_q <= rst_state_d;
			busy_q <= (rst_state_d == RST_RECOVER);
			// one-cycle pulse tells the rest of the device to restore defaults
			o_soft_reset <= accept_reset;
		end
	end

	// Recovery counter
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rcv_cnt_q <= 11'h000;
		end else if (rst_state_q == RST_RECOVER) begin
			rcv_cnt_q <= rcv_cnt_q + 11'h001;
		end else begin
			rcv_cnt_q <= 11'h000;
		end
	end

	// Four-wire command mode flag
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			qpi_q <= 1'b0;
		end else if (accept_reset) begin
			qpi_q <= 1'b0;
		end else if (commit && lk_op_q == OP_EXIT_QPI && qpi_q) begin
			// exit; no reset pulse, so latch, suspend and wrap are untouched
			qpi_q <= 1'b0;
		end else if (commit && lk_op_q == OP_ENTER_QPI && !qpi_q && i_quad_enable_bit) begin
			// entry only with quad enable set
			qpi_q <= 1'b1;
		end
	end

	assign o_four_wire_command_mode = qpi_q;
	assign o_reset_busy = busy_q;

	// Lock bits
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lock_q <= {LOCK_COUNT{LOCK_RESET_VALUE}};
		end else if (accept_reset) begin
			lock_q <= {LOCK_COUNT{LOCK_RESET_VALUE}};
		end else if (commit) begin
			case (lk_op_q)
				OP_GLOBAL_LOCK: lock_q <= {LOCK_COUNT{1'b1}};
				OP_GLOBAL_UNLOCK: lock_q <= {LOCK_COUNT{1'b0}};
				OP_LOCK: begin
					// set the one covering bit; low address bits ignored
					if (lk_addr_done_q) begin
						lock_q[lock_index(lk_addr_q)] <= 1'b1;
					end
				end
				OP_UNLOCK: begin
					if (lk_addr_done_q) begin
						lock_q[lock_index(lk_addr_q)] <= 1'b0;
					end
				end
				default: lock_q <= lock_q;
			endcase
		end
	end

	// Protection answer for the array engines
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_check_protected <= 1'b1;
		end else if (i_protect_scheme_select) begin
			o_check_protected <= lock_q[lock_index(i_check_addr)];
		end else begin
			o_check_protected <= field_protected(i_check_addr, i_block_protect_field, i_top_bottom_select,
				i_protect_complement);
		end
	end

	qpi_exit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		commit && lk_op_q == OP_EXIT_QPI && qpi_q |=> !o_four_wire_command_mode)
		else $error("four-wire mode not left after exit opcode");

	exit_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		commit && lk_op_q == OP_EXIT_QPI |=> !o_soft_reset)
		else $error("exit opcode disturbed preserved state");

	scheme_lock_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		i_protect_scheme_select |=> o_check_protected == $past(lock_q[lock_index(i_check_addr)]))
		else $error("lock bit not used when scheme bit set");

	scheme_legacy_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!i_protect_scheme_select && i_block_protect_field == 4'h0 && !i_protect_complement
		|=> !o_check_protected)
		else $error("empty legacy field reported protected");

	reset_locks_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_soft_reset |-> &lock_q)
		else $error("lock bits not all set after reset");

	global_lock_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		commit && lk_op_q == OP_GLOBAL_LOCK |=> &lock_q)
		else $error("global lock left a bit clear");

	global_unlock_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		commit && lk_op_q == OP_GLOBAL_UNLOCK && !accept_reset |=> lock_q == '0)
		else $error("global unlock left a bit set");

	reset_disarm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		commit && rst_state_q == RST_ARMED && lk_op_q != OP_RESET && lk_op_q != OP_RESET_ENABLE
		|=> rst_state_q == RST_IDLE)
		else $error("reset enable survived another opcode");

	recover_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_soft_reset |-> o_reset_busy [*8] ##0 !$changed(qpi_q))
		else $error("recovery interval cut short");

	quad_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		commit && lk_op_q == OP_ENTER_QPI && !i_quad_enable_bit && !qpi_q |=> !o_four_wire_command_mode)
		else $error("four-wire mode entered without quad enable");

endmodule

// File: test/flrc_host_model.sv
/*
 Host serial controller model that frames instructions for the lock and reset command block.
 Assumes mode 0 framing and a caller that runs one frame at a time.
*/
module flrc_host_model (
	// Link to the device
	output logic o_spi_clk,
	output logic o_spi_cs_n,
	output logic [3:0] o_io,
	output logic o_drive,
	// Resolved data lines and device enables
	input wire logic [3:0] i_io,
	input wire logic [3:0] i_dev_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 24; // 48 ns link period
	logic [3:0] last_oe;

	// Idle link: clock parked low, chip select high
	initial begin
		o_spi_clk = 1'b0;
		o_spi_cs_n = 1'b1;
		o_io = 4'h5;
		o_drive = 1'b0;
		last_oe = 4'h0;
	end

	// Shift MSB first; unused lines toggle so stale values never look valid
	task automatic send(input logic four_wire_command_mode, input logic [31:0] v, input int nbits);
		for (int i = 0; i < nbits; i += (four_wire_command_mode ? 4 : 1)) begin
			o_io = four_wire_command_mode ? v[31:28] : {~o_io[3:1], v[31]};
			v = four_wire_command_mode ? (v << 4) : (v << 1);
			#HALF o_spi_clk = 1'b1;
			#HALF o_spi_clk = 1'b0;
		end
	endtask

	task automatic frame(input logic four_wire_command_mode, input logic [7:0] op, input int abits, input logic [31:0] addr,
			input logic rd_en, output logic [7:0] rd);
		rd = 8'h00;
		o_spi_cs_n = 1'b0;
		o_drive = 1'b1;
		#11;
		send(four_wire_command_mode, {op, 24'h0}, 8);
		send(four_wire_command_mode, (abits == 24) ? (addr << 8) : addr, abits);
		if (rd_en) begin
			o_drive = 1'b0;
			o_io = ~o_io;
			for (int i = 0; i < (four_wire_command_mode ? 2 : 8); i++) begin
				#HALF o_spi_clk = 1'b1;
				rd = four_wire_command_mode ? {rd[3:0], i_io} : {rd[6:0], i_io[1]};
				last_oe = i_dev_oe;
				#HALF o_spi_clk = 1'b0;
			end
		end
		#11;
		o_spi_cs_n = 1'b1;
		o_drive = 1'b0;
		o_io = ~o_io;
		#200;
	endtask
endmodule

// File: test/flash_lock_and_reset_commands_test.sv
/*
 Self-checking bench for the lock and reset command block, with a host model on the link.
 Assumes the design package constants and a 40 MHz reference clock.
*/
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED %0t %s", $time, msg); end end
module flash_lock_and_reset_commands_test;
	timeunit 1ns;
	timeprecision 100ps;
	import flrc_pkg::*;
	logic ref_clk = 1'b0, rstn, spi_clk, cs_n, host_drive, quad_en, fbm, scheme_sel, inv_sel, tbs, prot, qmode;
	logic srst, rbusy;
	logic [3:0] host_io, io_wire, io_out, io_oe, bpf;
	logic [31:0] chk_addr, a, b;
	logic [7:0] rd;
	logic q_exp;
	int errors, comparisons, seed, pulses, busy_cycles, cycles, k0;

	flrc_top u_flrc_top (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_spi_clk(spi_clk), .i_spi_cs_n(cs_n),
		.i_io_in(io_wire), .o_io_out(io_out), .o_io_oe(io_oe), .i_quad_enable_bit(quad_en),
		.i_four_byte_mode(fbm), .i_protect_scheme_select(scheme_sel), .i_protect_complement(inv_sel),
		.i_top_bottom_select(tbs), .i_block_protect_field(bpf), .i_check_addr(chk_addr),
		.o_check_protected(prot), .o_four_wire_command_mode(qmode), .o_soft_reset(srst), .o_reset_busy(rbusy));
	flrc_host_model u_flrc_host_model (.o_spi_clk(spi_clk), .o_spi_cs_n(cs_n), .o_io(host_io),
		.o_drive(host_drive), .i_io(io_wire), .i_dev_oe(io_oe));

	// Wire level: the device drives the lines it enables, the host value shows on all the others
	assign io_wire = (io_oe & io_out) | (~io_oe & host_io);

	// While the host drives the lines the device must keep its enables low
	always @(posedge spi_clk) if (host_drive) `CHK(io_oe, 4'h0, "device drove during host phase")

	always #12.5 ref_clk = ~ref_clk;

	// Pulse and busy counters, plus the hang limit
	always @(posedge ref_clk) begin
		cycles++;
		if (srst === 1'b1) pulses++;
		if (rbusy === 1'b1) busy_cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic settle();
		repeat (4) @(posedge ref_clk);
		#2;
	endtask

	// One framed instruction; the address width follows the four-byte setting
	task automatic run(input logic [7:0] op, input logic [31:0] ad, output logic [7:0] r);
		int ab;
		ab = (op == OP_LOCK || op == OP_UNLOCK || op == OP_READ_LOCK) ? (fbm ? 32 : 24) : 0;
		u_flrc_host_model.frame(q_exp, op, ab, ad, op == OP_READ_LOCK, r);
		repeat (8) @(posedge ref_clk);
		#2;
	endtask

	task automatic query(input logic [31:0] ad);
		chk_addr = ad;
		repeat (2) @(posedge ref_clk);
		#2;
	endtask

	// Legacy scheme: 2^(f-1) blocks from bottom or top, all at 512 or more
	function automatic logic legacy(input logic [31:0] ad, input logic [3:0] f, input logic t, input logic c);
		int n;
		int blk;
		logic hit;
		n = (f == 4'h0) ? 0 : (1 << (f - 1));
		blk = ad[24:16];
		hit = (n >= 512) ? 1'b1 : (t ? (blk < n) : (blk >= 512 - n));
		return hit ^ c;
	endfunction

	// End blocks split into 4 KB sectors, the rest lock whole
	function automatic logic same_unit(input logic [31:0] x, input logic [31:0] y);
		return (x[24:16] == y[24:16]) && ((x[24:16] != 9'h000 && x[24:16] != 9'h1FF) || x[15:12] == y[15:12]);
	endfunction

	initial begin
		seed = 32'h19bf;
		{rstn, quad_en, fbm, inv_sel, tbs, q_exp} = 6'h00;
		scheme_sel = 1'b1;
		bpf = 4'h0;
		chk_addr = 32'h0000_0000;
		repeat (6) @(posedge ref_clk);
		#2;
		rstn = 1'b1;
		settle();
		// Power-up state is fully locked
		a = $random(seed) & 32'h00FF_FFFF;
		query(a);
		`CHK(prot, 1'b1, "not locked after reset")
		run(OP_READ_LOCK, a, rd);
		`CHK(rd, 8'h01, "lock byte after reset")
		`CHK(u_flrc_host_model.last_oe, 4'h2, "serial read enable")
		run(OP_GLOBAL_UNLOCK, 32'h0, rd);
		for (int k = 0; k < 3; k++) begin
			query($random(seed) & 32'h01FF_FFFF);
			`CHK(prot, 1'b0, "global unlock missed")
		end
		// Single unit lock and unlock, split end blocks first, both address widths
		for (int k = 0; k < 6; k++) begin
			fbm = k[0];
			a = (k == 0) ? 32'h0000_3000 : (k == 1) ? 32'h01FF_F123 : $random(seed) & (fbm ? 32'h01FF_FFFF : 32'h00FF_FFFF);
			b = a ^ 32'h0000_1000;
			settle();
			run(OP_LOCK, a, rd);
			run(OP_READ_LOCK, a ^ 32'h0000_0FFF, rd);
			`CHK(rd, 8'h01, "unit not locked")
			run(OP_READ_LOCK, b, rd);
			`CHK(rd, {7'h00, same_unit(a, b)}, "neighbour lock state")
			query(a);
			`CHK(prot, 1'b1, "lock not protecting")
			run(OP_UNLOCK, a, rd);
			run(OP_READ_LOCK, a, rd);
			`CHK(rd, 8'h00, "unit not unlocked")
		end
		fbm = 1'b0;
		scheme_sel = 1'b0;
		// Legacy protection with boundary fields first
		for (int k = 0; k < 8; k++) begin
			bpf = (k == 0) ? 4'h0 : (k == 1) ? 4'hA : 4'($random(seed));
			tbs = 1'($random(seed));
			inv_sel = 1'($random(seed));
			a = $random(seed) & 32'h01FF_FFFF;
			query(a);
			`CHK(prot, legacy(a, bpf, tbs, inv_sel), "legacy protection")
		end
		scheme_sel = 1'b1;
		query(a);
		`CHK(prot, 1'b0, "lock scheme ignored")
		run(OP_GLOBAL_LOCK, 32'h0, rd);
		query(a);
		`CHK(prot, 1'b1, "global lock missed")
		run(OP_GLOBAL_UNLOCK, 32'h0, rd);
		// Four-wire mode entry needs quad enable
		run(OP_ENTER_QPI, 32'h0, rd);
		`CHK(qmode, 1'b0, "entered without quad enable")
		quad_en = 1'b1;
		settle();
		run(OP_ENTER_QPI, 32'h0, rd);
		`CHK(qmode, 1'b1, "four-wire entry")
		q_exp = 1'b1;
		a = $random(seed) & 32'h00FF_FFFF;
		b = a ^ 32'h0080_0000;
		run(OP_LOCK, a, rd);
		// Read back with eight address nibbles to cover four-byte mode in four-wire framing
		fbm = 1'b1;
		run(OP_READ_LOCK, a, rd);
		`CHK(rd, 8'h01, "four-wire lock byte")
		`CHK(u_flrc_host_model.last_oe, 4'hF, "four-wire read enable")
		// exit is only sent while in four-wire mode
		run(OP_EXIT_QPI, 32'h0, rd);
		q_exp = 1'b0;
		`CHK(qmode, 1'b0, "four-wire exit")
		// Reset pair broken by another instruction
		k0 = pulses;
		run(OP_RESET_ENABLE, 32'h0, rd);
		run(OP_READ_LOCK, a, rd);
		run(OP_RESET, 32'h0, rd);
		`CHK(pulses, k0, "reset not disarmed")
		// reset pair in four-wire mode, nothing busy or suspended
		run(OP_ENTER_QPI, 32'h0, rd);
		q_exp = 1'b1;
		run(OP_RESET_ENABLE, 32'h0, rd);
		busy_cycles = 0;
		run(OP_RESET, 32'h0, rd);
		q_exp = 1'b0;
		`CHK(pulses, k0 + 1, "reset pulse")
		`CHK(rbusy, 1'b1, "recovery busy")
		`CHK(qmode, 1'b0, "mode after reset")
		run(OP_GLOBAL_UNLOCK, 32'h0, rd);
		for (int k = 0; k < 1300 && rbusy !== 1'b0; k++) @(posedge ref_clk);
		#2;
		`CHK(busy_cycles, RESET_RECOVERY_CYCLES, "recovery length")
		query(b);
		`CHK(prot, 1'b1, "locks after reset")
		run(OP_GLOBAL_UNLOCK, 32'h0, rd);
		query(b);
		`CHK(prot, 1'b0, "instruction after recovery")
		// Mid-run hardware reset must protect the whole array again
		rstn = 1'b0;
		repeat (2) @(posedge ref_clk);
		#2;
		rstn = 1'b1;
		settle();
		query(b);
		`CHK(prot, 1'b1, "locks after hardware reset")
		wrap_up();
	end
endmodule
